// [hdl/mmupc_top.sv]
// Permission checker, fault status capture, flush trigger and control word
`timescale 1ns/10ps
`include "mmupc_map.svh"
module mmupc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Access check request
   input wire logic acc_valid,
   input wire logic [2:0] acc_type,
   input wire mmupc_pkg::mmupc_perm_t acc_perm,
   input wire logic [1:0] acc_level,
   input wire logic acc_block,
   input wire logic acc_word,
   input wire logic acc_instr,
   input wire logic acc_invalid,
   input wire logic acc_xlate_fail,
   input wire logic acc_misalign,
   output logic acc_fault,
   output logic acc_ignore,
   output logic acc_grant,
   // Memory bus error report
   input wire logic bus_err_valid,
   input wire logic bus_err_uncorr,
   input wire logic bus_err_timeout,
   input wire logic bus_err_buserr,
   input wire logic bus_err_event,
   input wire logic bus_err_remote,
   input wire logic bus_err_write,
   input wire logic bus_err_swapped,
   input wire logic bus_err_pending,
   // Register access
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [1:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   // Translation cache and pins
   output logic flush_all,
   output logic flush_test,
   output logic translation_on,
   output logic ext_soft_reset_out,
   output logic int_soft_reset,
   // Command engine
   input wire logic cmd_engine_trap,
   input wire logic cmd_start,
   output logic cmd_engine_clear,
   output logic cmd_go,
   // Queue engines and receivers
   input wire logic [2:0] q_desched,
   input wire logic [2:0] q_at_halt,
   output logic [2:0] q_hold_off,
   input wire logic [1:0] rx_desched,
   input wire logic [1:0] rx_at_eop,
   output logic [1:0] rx_hold_off,
   // Timebase and links
   output logic [1:0] speed_meter_select,
   input wire logic link_a_held_reset,
   input wire logic link_b_held_reset,
   input wire logic link_a_err,
   input wire logic link_b_err
);
   // ==========================================
   // Storage
   logic [31:0] fault_status_reg_ff; // Captured fault information
   logic captured_ff; // Fault held until read
   logic [15:0] ctrl_ff; // Writable control bits
   logic trapped_ff; // Command engine trap flag
   logic link_a_line_fault_ff;
   logic link_b_line_fault_ff;
   logic [31:0] rdata_ff;
   logic flush_all_ff;
   logic flush_test_ff;
   logic queue_engines_stopped;
   logic receivers_stopped;
   mmupc_pkg::mmupc_res_t perm_res;
   logic [2:0] ft_code;
   logic any_bus_error_flag;
   logic perm_fault;
   logic wr_ctrl;
   logic rd_fsr;

   assign wr_ctrl = reg_wr && reg_sel == `MMUPC_SEL_CTRL;
   assign rd_fsr = reg_rd && reg_sel == `MMUPC_SEL_FSR;

   // ==========================================
   // Permission check
   mmupc_perm_check u_perm (
      .acc_type(acc_type),
      .perm(acc_perm),
      .result(perm_res)
   );

   // Other fault sources outrank the permission table
   always_comb begin
      ft_code = `MMUPC_FT_NONE;
      if (acc_misalign) begin
         ft_code = `MMUPC_FT_ALIGN;
      end else if (acc_invalid) begin
         ft_code = `MMUPC_FT_INVALID;
      end else if (acc_xlate_fail) begin
         ft_code = `MMUPC_FT_XLATE;
      end else if (perm_res == mmupc_pkg::MMUPC_RES_FAULT) begin
         ft_code = `MMUPC_FT_PROT;
      end
   end

   // Check bypassed while translation is off
   assign perm_fault = acc_valid && translation_on && ft_code != `MMUPC_FT_NONE;
   // ignored access fails cycle with distinct code
   assign acc_ignore = acc_valid && translation_on && ft_code == `MMUPC_FT_NONE
                       && perm_res == mmupc_pkg::MMUPC_RES_IGNORE;
   assign acc_fault = perm_fault;
   assign acc_grant = acc_valid && !perm_fault && !acc_ignore;
   assign any_bus_error_flag = bus_err_valid;

   // ==========================================
   // Fault status capture
   // first fault held until read; a new fault in the read cycle is kept
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fault_status_reg_ff <= 32'h00000000;
         captured_ff <= 1'b0;
      end else if ((!captured_ff || rd_fsr) && (any_bus_error_flag || perm_fault)) begin
         fault_status_reg_ff <= 32'h00000000;
         captured_ff <= 1'b1;
         if (any_bus_error_flag) begin
            fault_status_reg_ff[`MMUPC_FSR_ANYERR] <= 1'b1;
            fault_status_reg_ff[`MMUPC_FSR_SWAP] <= bus_err_swapped;
            fault_status_reg_ff[`MMUPC_FSR_ERR3] <= bus_err_uncorr;
            fault_status_reg_ff[`MMUPC_FSR_ERR2] <= bus_err_timeout;
            fault_status_reg_ff[`MMUPC_FSR_ERR1] <= bus_err_buserr;
            fault_status_reg_ff[`MMUPC_FSR_EVENT] <= bus_err_event;
            fault_status_reg_ff[`MMUPC_FSR_REMOTE] <= bus_err_remote;
            fault_status_reg_ff[`MMUPC_FSR_WRITE] <= bus_err_write;
            fault_status_reg_ff[9:8] <= 2'h0;
            fault_status_reg_ff[4:2] <= `MMUPC_FT_BUSERR;
            fault_status_reg_ff[`MMUPC_FSR_FAV] <= 1'b1;
         end else begin
            fault_status_reg_ff[`MMUPC_FSR_BLOCK] <= acc_block;
            fault_status_reg_ff[`MMUPC_FSR_WORD] <= acc_word;
            fault_status_reg_ff[`MMUPC_FSR_INSTR] <= acc_instr;
            fault_status_reg_ff[9:8] <= acc_level;
            fault_status_reg_ff[`MMUPC_FSR_EVENT] <= acc_type[2];
            fault_status_reg_ff[`MMUPC_FSR_REMOTE] <= acc_type[1];
            fault_status_reg_ff[`MMUPC_FSR_WRITE] <= acc_type[0];
            fault_status_reg_ff[4:2] <= ft_code;
            fault_status_reg_ff[`MMUPC_FSR_FAV] <= 1'b1;
         end
      end else if (rd_fsr) begin
         captured_ff <= 1'b0;
      end
   end

   // ==========================================
   // Flush register
   // zero write invalidates, others are test writes
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flush_all_ff <= 1'b0;
         flush_test_ff <= 1'b0;
      end else begin
         flush_all_ff <= reg_wr && reg_sel == `MMUPC_SEL_FLUSH && reg_wdata == `MMUPC_FLUSH_CMD;
         flush_test_ff <= reg_wr && reg_sel == `MMUPC_SEL_FLUSH && reg_wdata != `MMUPC_FLUSH_CMD;
      end
   end
   assign flush_all = flush_all_ff;
   assign flush_test = flush_test_ff;

   // ==========================================
   // Control word writable bits
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= `MMUPC_CW_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff[`MMUPC_CW_XLATE] <= reg_wdata[`MMUPC_CW_XLATE];
         ctrl_ff[`MMUPC_CW_EXTRST] <= reg_wdata[`MMUPC_CW_EXTRST];
         ctrl_ff[`MMUPC_CW_INTRST] <= reg_wdata[`MMUPC_CW_INTRST];
         ctrl_ff[`MMUPC_CW_CMDCLR] <= reg_wdata[`MMUPC_CW_CMDCLR];
         ctrl_ff[`MMUPC_CW_STOPQ] <= reg_wdata[`MMUPC_CW_STOPQ];
         ctrl_ff[`MMUPC_CW_STOPRX] <= reg_wdata[`MMUPC_CW_STOPRX];
         ctrl_ff[`MMUPC_CW_SPEED_HI:`MMUPC_CW_SPEED_LO] <= reg_wdata[`MMUPC_CW_SPEED_HI:`MMUPC_CW_SPEED_LO];
         ctrl_ff[`MMUPC_CW_SYNC] <= reg_wdata[`MMUPC_CW_SYNC];
      end else if (ctrl_ff[`MMUPC_CW_INTRST]) begin
         // internal reset clears only its own bit
         ctrl_ff[`MMUPC_CW_INTRST] <= 1'b0;
      end
   end

   // One-cycle internal reset pulse; other control bits untouched
   assign int_soft_reset = ctrl_ff[`MMUPC_CW_INTRST];
   assign translation_on = ctrl_ff[`MMUPC_CW_XLATE];
   assign ext_soft_reset_out = ctrl_ff[`MMUPC_CW_EXTRST];
   assign speed_meter_select = ctrl_ff[`MMUPC_CW_SPEED_HI:`MMUPC_CW_SPEED_LO];

   // ==========================================
   // Command engine trap
   // clear bit resets engine and trap flag; new trap wins
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trapped_ff <= 1'b0;
      end else if (cmd_engine_trap) begin
         trapped_ff <= 1'b1;
      end else if (ctrl_ff[`MMUPC_CW_CMDCLR]) begin
         trapped_ff <= 1'b0;
      end
   end
   assign cmd_engine_clear = ctrl_ff[`MMUPC_CW_CMDCLR];
   // wait for outstanding bus errors when sync set
   assign cmd_go = cmd_start && !cmd_engine_clear
                   && !(ctrl_ff[`MMUPC_CW_SYNC] && bus_err_pending);

   // ==========================================
   // Halt control
   // queue engines held at halt point
   mmupc_stop_ctrl #(.N(3)) u_stop_q (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .stop_req(ctrl_ff[`MMUPC_CW_STOPQ]),
      .desched(q_desched),
      .at_halt_point(q_at_halt),
      .hold_off(q_hold_off),
      .all_stopped(queue_engines_stopped)
   );
   mmupc_stop_ctrl #(.N(2)) u_stop_rx (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .stop_req(ctrl_ff[`MMUPC_CW_STOPRX]),
      .desched(rx_desched),
      .at_halt_point(rx_at_eop),
      .hold_off(rx_hold_off),
      .all_stopped(receivers_stopped)
   );

   // ==========================================
   // Link error latches
   // set wins over write-one-to-clear
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         link_a_line_fault_ff <= 1'b0;
         link_b_line_fault_ff <= 1'b0;
      end else begin
         link_a_line_fault_ff <= link_a_err
                                 || (link_a_line_fault_ff && !(wr_ctrl && reg_wdata[`MMUPC_CW_LINKA_ERR]));
         link_b_line_fault_ff <= link_b_err
                                 || (link_b_line_fault_ff && !(wr_ctrl && reg_wdata[`MMUPC_CW_LINKB_ERR]));
      end
   end

   // ==========================================
   // Read data, registered
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= 32'h00000000;
      end else if (reg_rd && reg_sel == `MMUPC_SEL_FSR) begin
         rdata_ff <= fault_status_reg_ff;
      end else if (reg_rd && reg_sel == `MMUPC_SEL_CTRL) begin
         rdata_ff <= 32'h00000000;
         rdata_ff[15:0] <= ctrl_ff;
         rdata_ff[`MMUPC_CW_TRAPPED] <= trapped_ff;
         rdata_ff[`MMUPC_CW_QSTOPPED] <= queue_engines_stopped;
         rdata_ff[`MMUPC_CW_RXSTOPPED] <= receivers_stopped;
         rdata_ff[`MMUPC_CW_LINKA_RST] <= link_a_held_reset;
         rdata_ff[`MMUPC_CW_LINKB_RST] <= link_b_held_reset;
         rdata_ff[`MMUPC_CW_LINKA_ERR] <= link_a_line_fault_ff;
         rdata_ff[`MMUPC_CW_LINKB_ERR] <= link_b_line_fault_ff;
      end else if (reg_rd) begin
         rdata_ff <= 32'h00000000;
      end
   end
   assign reg_rdata = rdata_ff;
endmodule

// [pkg/mmupc_map.svh]
// Offsets, field positions, reset values and encodings for the permission and control block
// Functional notes
// - Bus error sets bit 28 and kind
// - Fault status flags block, word, instruction access
// - Bits 9:8 hold level, zero on bus error
// - Bits 7,6,5 flag event, remote, write
// - Type code 4:2, valid bit 1, rest zero
// - Fault codes 1,2,4,5,7; others unused
// - Access type: write, remote, event bits
// - Null page faults local, ignores remote
// - Graded permissions, remote never above local
// - Ignored access fails cycle, distinct code
// - Zero write to flush invalidates cache
// - Control bit 0 enables translation
// - Control bit 1 drives output pin
// - Bit 2 internal reset, clears itself only
// - Bit 4 trapped, bit 3 clears engine
// - Bit 5 holds queue engines at halt
// - Bit 6 holds receivers at packet end
// - Bits 7,8 report all engines halted
// - Field 10:9 selects seconds counter clock
// - Bits 11,12 show links in reset
// - Bits 13,14 latch link errors, W1C
// - Bit 15 syncs commands; 31:16 zero
`ifndef MMUPC_MAP_SVH
`define MMUPC_MAP_SVH

// ==========================================
// Register select codes
`define MMUPC_SEL_FSR 2'h0
`define MMUPC_SEL_CTRL 2'h1
`define MMUPC_SEL_FLUSH 2'h2

// ==========================================
// Fault status fields
`define MMUPC_FSR_ANYERR 28
`define MMUPC_FSR_SWAP 21
`define MMUPC_FSR_BLOCK 20
`define MMUPC_FSR_WORD 19
`define MMUPC_FSR_INSTR 18
`define MMUPC_FSR_ERR3 12
`define MMUPC_FSR_ERR2 11
`define MMUPC_FSR_ERR1 10
`define MMUPC_FSR_EVENT 7
`define MMUPC_FSR_REMOTE 6
`define MMUPC_FSR_WRITE 5
`define MMUPC_FSR_FAV 1

// ==========================================
// Fault type codes
`define MMUPC_FT_NONE 3'h0
`define MMUPC_FT_INVALID 3'h1
`define MMUPC_FT_PROT 3'h2
`define MMUPC_FT_XLATE 3'h4
`define MMUPC_FT_BUSERR 3'h5
`define MMUPC_FT_ALIGN 3'h7

// ==========================================
// Control word fields
`define MMUPC_CW_XLATE 0
`define MMUPC_CW_EXTRST 1
`define MMUPC_CW_INTRST 2
`define MMUPC_CW_CMDCLR 3
`define MMUPC_CW_TRAPPED 4
`define MMUPC_CW_STOPQ 5
`define MMUPC_CW_STOPRX 6
`define MMUPC_CW_QSTOPPED 7
`define MMUPC_CW_RXSTOPPED 8
`define MMUPC_CW_SPEED_LO 9
`define MMUPC_CW_SPEED_HI 10
`define MMUPC_CW_LINKA_RST 11
`define MMUPC_CW_LINKB_RST 12
`define MMUPC_CW_LINKA_ERR 13
`define MMUPC_CW_LINKB_ERR 14
`define MMUPC_CW_SYNC 15
`define MMUPC_CW_RESET 16'h0000
`define MMUPC_FLUSH_CMD 32'h00000000

`endif

// [pkg/mmupc_pkg.sv]
// Types for the permission and control block
package mmupc_pkg;
   // Page permission grades, lowest first
   typedef enum logic [2:0] {
      MMUPC_PERM_NULL,
      MMUPC_PERM_LOCAL_READ,
      MMUPC_PERM_READ,
      MMUPC_PERM_NO_REMOTE,
      MMUPC_PERM_REMOTE_READ,
      MMUPC_PERM_REMOTE_WRITE,
      MMUPC_PERM_REMOTE_EVENT,
      MMUPC_PERM_REMOTE_ALL
   } mmupc_perm_t;
   // Outcome of a permission check
   typedef enum logic [1:0] {
      MMUPC_RES_OK,
      MMUPC_RES_FAULT,
      MMUPC_RES_IGNORE
   } mmupc_res_t;
endpackage

// [hdl/mmupc_perm_check.sv]
// Permission table lookup for one access
`timescale 1ns/10ps
module mmupc_perm_check (
   // Access
   input wire logic [2:0] acc_type,
   input wire mmupc_pkg::mmupc_perm_t perm,
   // Result
   output mmupc_pkg::mmupc_res_t result
);
   // ==========================================
   // Decode
   logic is_write;
   logic is_remote;
   logic is_event;
   assign is_write = acc_type[0];
   assign is_remote = acc_type[1];
   assign is_event = acc_type[2];

   // Table of grades; remote reads lost at MMUPC_PERM_NO_REMOTE, remote writes lost at MMUPC_PERM_REMOTE_EVENT
   always_comb begin
      logic allow;
      allow = 1'b0;
      result = mmupc_pkg::MMUPC_RES_FAULT;
      case (perm)
         mmupc_pkg::MMUPC_PERM_LOCAL_READ: allow = !is_remote && !is_write && !is_event;
         mmupc_pkg::MMUPC_PERM_READ: allow = !is_write && !is_event;
         mmupc_pkg::MMUPC_PERM_NO_REMOTE: allow = !is_remote;
         mmupc_pkg::MMUPC_PERM_REMOTE_READ: allow = !is_remote || (!is_write && !is_event);
         mmupc_pkg::MMUPC_PERM_REMOTE_WRITE: allow = !is_remote || !is_event;
         mmupc_pkg::MMUPC_PERM_REMOTE_EVENT: allow = !is_remote || is_event || !is_write;
         mmupc_pkg::MMUPC_PERM_REMOTE_ALL: allow = 1'b1;
         default: allow = 1'b0;
      endcase
      if (allow) begin
         result = mmupc_pkg::MMUPC_RES_OK;
      end
      else if (perm == mmupc_pkg::MMUPC_PERM_NULL && is_remote) begin
         result = mmupc_pkg::MMUPC_RES_IGNORE;
      end
   end
endmodule

// [hdl/mmupc_stop_ctrl.sv]
// Halt request and halt status for a group of engines
`timescale 1ns/10ps
module mmupc_stop_ctrl #(
   parameter int N = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Request and engine status
   input wire logic stop_req,
   input wire logic [N-1:0] desched,
   input wire logic [N-1:0] at_halt_point,
   // Results
   output logic [N-1:0] hold_off,
   output logic all_stopped
);
   // ==========================================
   // Parked engines
   logic [N-1:0] parked_ff;

   // An engine parks when descheduled at its halt point while stop requested
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         parked_ff <= '0;
      end else if (!stop_req) begin
         parked_ff <= '0;
      end else begin
         parked_ff <= parked_ff | (desched & at_halt_point);
      end
   end

   // Mid-point deschedules are never held
   assign hold_off = parked_ff;
   assign all_stopped = stop_req && (&parked_ff);
endmodule

// [testbench/mmupc_checker.sv]
// Port assertions for the permission and control block
`timescale 1ns/10ps
module mmupc_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Access check
   input wire logic acc_valid,
   input wire logic [2:0] acc_type,
   input wire mmupc_pkg::mmupc_perm_t acc_perm,
   input wire logic acc_invalid,
   input wire logic acc_xlate_fail,
   input wire logic acc_misalign,
   input wire logic acc_fault,
   input wire logic acc_ignore,
   input wire logic acc_grant,
   // Registers and pins
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [1:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic flush_all,
   input wire logic flush_test,
   input wire logic translation_on,
   input wire logic ext_soft_reset_out,
   input wire logic int_soft_reset,
   input wire logic [1:0] speed_meter_select,
   // Engines
   input wire logic bus_err_pending,
   input wire logic cmd_start,
   input wire logic cmd_engine_clear,
   input wire logic cmd_go,
   input wire logic [2:0] q_hold_off
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadow copies of the sync and queue stop bits
   logic sync_ff;
   logic stopq_ff;
   wire cw_wr = reg_wr && reg_sel == 2'h1;
   // Access with no fault source other than the permission
   wire clean = !acc_invalid && !acc_xlate_fail && !acc_misalign;
   // ==========================================
   // Shadow of control bits the checker cannot see
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sync_ff <= 1'b0;
         stopq_ff <= 1'b0;
      end else if (cw_wr) begin
         sync_ff <= reg_wdata[15];
         stopq_ff <= reg_wdata[5];
      end
   end
   // ==========================================
   // Register write steps
   sequence s_cw_wr;
      cw_wr;
   endsequence
   sequence s_flush0;
      reg_wr && reg_sel == 2'h2 && reg_wdata == 32'h0;
   endsequence
   sequence s_irst;
      cw_wr && reg_wdata[2];
   endsequence
   // ==========================================
   // Properties
   property p_one;
      acc_valid |-> $onehot({acc_fault, acc_ignore, acc_grant});
   endproperty
   property p_null;
      acc_valid && translation_on && acc_perm == mmupc_pkg::MMUPC_PERM_NULL && clean
         |-> (acc_type[1] ? acc_ignore : acc_fault);
   endproperty
   property p_lread;
      acc_valid && translation_on && acc_perm == mmupc_pkg::MMUPC_PERM_LOCAL_READ && acc_type != 3'h0 |-> acc_fault;
   endproperty
   property p_all;
      acc_valid && translation_on && acc_perm == mmupc_pkg::MMUPC_PERM_REMOTE_ALL && clean |-> acc_grant;
   endproperty
   property p_flush;
      s_flush0 |=> flush_all && !flush_test;
   endproperty
   property p_ftest;
      reg_wr && reg_sel == 2'h2 && reg_wdata != 32'h0 |=> flush_test && !flush_all;
   endproperty
   property p_en;
      s_cw_wr |=> translation_on == $past(reg_wdata[0]) && ext_soft_reset_out == $past(reg_wdata[1]);
   endproperty
   property p_speed;
      s_cw_wr |=> speed_meter_select == $past(reg_wdata[10:9]);
   endproperty
   property p_irst;
      s_irst |=> int_soft_reset ##1 !int_soft_reset;
   endproperty
   property p_fsr0;
      reg_rd && reg_sel == 2'h0 |=> reg_rdata[31:29] == 3'h0 && reg_rdata[27:22] == 6'h0
         && reg_rdata[17:13] == 5'h0 && !reg_rdata[0];
   endproperty
   property p_cw0;
      reg_rd && reg_sel == 2'h1 |=> reg_rdata[31:16] == 16'h0;
   endproperty
   property p_go;
      cmd_go == (cmd_start && !cmd_engine_clear && !(sync_ff && bus_err_pending));
   endproperty
   property p_hold;
      $fell(stopq_ff) |-> ##[1:2] q_hold_off == 3'h0;
   endproperty
   a_one: assert property (p_one) else $error("access result not one-hot");
   a_null: assert property (p_null) else $error("null page result wrong");
   a_lread: assert property (p_lread) else $error("local read page let access pass");
   a_all: assert property (p_all) else $error("full rights page refused access");
   a_flush: assert property (p_flush) else $error("zero flush write gave no flush");
   a_ftest: assert property (p_ftest) else $error("nonzero flush write wrong");
   a_en: assert property (p_en) else $error("enable or reset pin not from control");
   a_speed: assert property (p_speed) else $error("speed select not from control");
   a_irst: assert property (p_irst) else $error("internal reset not one pulse");
   a_fsr0: assert property (p_fsr0) else $error("fault status spare bits set");
   a_cw0: assert property (p_cw0) else $error("control upper half not zero");
   a_go: assert property (p_go) else $error("command go wrong");
   a_hold: assert property (p_hold) else $error("queue hold stayed after stop cleared");
endmodule

bind mmupc_top mmupc_checker chk_u (.*);

// [testbench/mmupc_engine_model.sv]
// Queue engines and receivers that park when held
`timescale 1ns/10ps
module mmupc_engine_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Hold requests
   input wire logic [2:0] q_hold_off,
   input wire logic [1:0] rx_hold_off,
   // Engine status
   output logic [2:0] q_desched,
   output logic [2:0] q_at_halt,
   output logic [1:0] rx_desched,
   output logic [1:0] rx_at_eop
);
   // Schedule slot; engines deschedule every fourth slot
   logic [2:0] slot_ff;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         slot_ff <= 3'h0;
      end else begin
         slot_ff <= slot_ff + 3'h1;
      end
   end
   assign q_desched = {3{slot_ff[1:0] == 2'h0}} | q_hold_off;
   assign q_at_halt = {3{slot_ff[2]}} | q_hold_off;
   assign rx_desched = {2{slot_ff[1:0] == 2'h0}} | rx_hold_off;
   assign rx_at_eop = {2{slot_ff == 3'h4}} | rx_hold_off;
endmodule

// [testbench/test_mmu_permission_and_control_word.sv]
// Self-checking bench for the permission and control block
`timescale 1ns/10ps
module test_mmu_permission_and_control_word;
   // ==========================================
   // Design nets
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic acc_valid, acc_block, acc_word, acc_instr, acc_invalid, acc_xlate_fail, acc_misalign;
   logic [2:0] acc_type;
   mmupc_pkg::mmupc_perm_t acc_perm;
   logic [1:0] acc_level, reg_sel, speed_meter_select, rx_desched, rx_at_eop, rx_hold_off;
   logic bus_err_valid, bus_err_uncorr, bus_err_timeout, bus_err_buserr, bus_err_event;
   logic bus_err_remote, bus_err_write, bus_err_swapped, bus_err_pending, reg_rd, reg_wr;
   logic [31:0] reg_wdata, reg_rdata;
   logic acc_fault, acc_ignore, acc_grant, flush_all, flush_test, translation_on;
   logic ext_soft_reset_out, int_soft_reset, cmd_engine_trap, cmd_start, cmd_engine_clear, cmd_go;
   logic [2:0] q_desched, q_at_halt, q_hold_off;
   logic link_a_held_reset, link_b_held_reset, link_a_err, link_b_err;
   // Bench state
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int seed;
   logic rd_seen = 1'b0;
   logic [63:0] rq[$];
   logic [2:0] aq[$];
   logic [63:0] r;
   mmupc_top dut_u (.*);
   mmupc_engine_model eng_u (.*);
   initial forever #50 clk_sys = ~clk_sys;
   // ==========================================
   // Helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Register write, one cycle strobe
   task automatic wr(input logic [1:0] s, input logic [31:0] d);
      @(posedge clk_sys) #1;
      {reg_wr, reg_sel, reg_wdata} = {1'b1, s, d};
      @(posedge clk_sys) #1;
      reg_wr = 1'b0;
   endtask
   // Register read; masked expectation noted for the monitor
   task automatic rd(input logic [1:0] s, input logic [31:0] m, input logic [31:0] e);
      rq.push_back({m, e & m});
      @(posedge clk_sys) #1;
      {reg_rd, reg_sel} = {1'b1, s};
      @(posedge clk_sys) #1;
      reg_rd = 1'b0;
   endtask
   // One access check held for one cycle
   task automatic acc(input int p, input int t, input logic [1:0] l, input logic [2:0] e);
      aq.push_back(e);
      @(posedge clk_sys) #1;
      {acc_valid, acc_type, acc_level} = {1'b1, 3'(t), l};
      acc_perm = mmupc_pkg::mmupc_perm_t'(p[2:0]);
      @(posedge clk_sys) #1;
      acc_valid = 1'b0;
   endtask
   // Expected {fault, ignore, grant} from the permission grades
   function automatic logic [2:0] perm_exp(input int p, input int t);
      logic [7:0] ok_map [8] = '{8'h00, 8'h01, 8'h05, 8'h33, 8'h37, 8'h3F, 8'hF7, 8'hFF};
      if (ok_map[p][t]) return 3'h1;
      if (p == 0 && t[1]) return 3'h2;
      return 3'h4;
   endfunction
   // ==========================================
   // Monitor: oldest note against each result
   always @(posedge clk_sys) begin
      if (rd_seen) begin
         r = rq.pop_front();
         chk("reg_rdata", reg_rdata & r[63:32], r[31:0]);
      end
      if (acc_valid) chk("acc_result", {29'h0, acc_fault, acc_ignore, acc_grant}, {29'h0, aq.pop_front()});
      rd_seen <= reg_rd;
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      seed = 32'h3E84;
      {acc_valid, acc_type, acc_level, acc_block, acc_word, acc_instr} = '0;
      {acc_invalid, acc_xlate_fail, acc_misalign, reg_rd, reg_wr, reg_sel, reg_wdata} = '0;
      {bus_err_valid, bus_err_uncorr, bus_err_timeout, bus_err_buserr, bus_err_event} = '0;
      {bus_err_remote, bus_err_write, bus_err_swapped, link_b_held_reset, link_a_err, link_b_err} = '0;
      {cmd_engine_trap, cmd_start, bus_err_pending, link_a_held_reset} = 4'hF;
      cmd_engine_trap = 1'b0;
      acc_perm = mmupc_pkg::MMUPC_PERM_NULL;
      repeat (2) @(posedge clk_sys);
      #1 nrst = 1'b1;
      rd(2'h1, 32'hFFFFFFFF, 32'h00000800);
      rd(2'h0, 32'hFFFFFFFF, 32'h0);
      acc(0, 1, 2'h0, 3'h1);
      wr(2'h1, 32'hFFFFFFF7);
      repeat (12) @(posedge clk_sys) #1 {cmd_start, bus_err_pending} = 2'($random(seed));
      rd(2'h1, 32'hFFFFFFFF, 32'h00008FE3);
      $display("control word test done");
      for (int i = 0; i < 4; i++) begin
         wr(2'h1, 32'(i) << 9);
         rd(2'h1, 32'hFFFFFFFF, (32'(i) << 9) | 32'h800);
      end
      @(posedge clk_sys) #1 cmd_engine_trap = 1'b1;
      @(posedge clk_sys) #1 cmd_engine_trap = 1'b0;
      rd(2'h1, 32'h18, 32'h10);
      wr(2'h1, 32'h8);
      rd(2'h1, 32'h18, 32'h08);
      {link_b_held_reset, link_a_err, link_b_err} = 3'h7;
      @(posedge clk_sys) #1 {link_a_err, link_b_err} = 2'h0;
      rd(2'h1, 32'h7800, 32'h7800);
      wr(2'h1, 32'h2000);
      rd(2'h1, 32'h7800, 32'h5800);
      $display("status bits test done");
      wr(2'h2, 32'h0);
      wr(2'h2, 32'($random(seed)) | 32'h1);
      wr(2'h1, 32'h1);
      for (int p = 0; p < 8; p++)
         for (int t = 0; t < 8; t++) acc(p, t, 2'($random(seed)), perm_exp(p, t));
      rd(2'h0, 32'h100000FC, 32'h08);
      $display("permission table test done");
      {acc_block, acc_word, acc_instr} = 3'h7;
      acc(1, 5, 2'h2, 3'h4);
      {acc_block, acc_word, acc_instr} = 3'h0;
      acc_misalign = 1'b1;
      acc(7, 0, 2'h1, 3'h4);
      acc_misalign = 1'b0;
      rd(2'h0, 32'hFFFFFFFF, 32'h001C02AA);
      for (int k = 0; k < 3; k++) begin
         {acc_misalign, acc_invalid, acc_xlate_fail} = 3'h4 >> k;
         acc(7, 6, 2'h0, 3'h4);
         {acc_misalign, acc_invalid, acc_xlate_fail} = 3'h0;
         rd(2'h0, 32'hFC, {24'h0, 6'h30 | (k == 0 ? 6'h7 : k == 1 ? 6'h1 : 6'h4), 2'h0});
      end
      $display("fault capture test done");
      @(posedge clk_sys) #1;
      {bus_err_timeout, bus_err_remote} = 2'h3;
      {bus_err_valid, bus_err_uncorr, bus_err_buserr, bus_err_event, bus_err_write, bus_err_swapped} = 6'h3F;
      @(posedge clk_sys) #1 bus_err_valid = 1'b0;
      acc(0, 0, 2'h3, 3'h4);
      rd(2'h0, 32'hFFE3FFFF, 32'h10201CF6);
      $display("bus error test done");
      repeat (3) @(posedge clk_sys);
      end_of_test();
   end
endmodule
